/* link_cfg_pkg.sv */
// Package: register map, field layout and timing constants of the link config
package link_cfg_pkg;

    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0] LINK_TIMING_OFS = 8'h84;
    localparam logic [7:0] NODE_ADDR_OFS   = 8'h85;
    localparam logic [7:0] LINK_INIT_OFS   = 8'h86;

    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int WDT_MSB    = 7;
    localparam int WDT_LSB    = 4;
    localparam int BWT_MSB    = 3;
    localparam int BWT_LSB    = 1;
    localparam int ACK_BIT    = 0;
    localparam int INTSEL_BIT = 4;
    localparam int PADDR_MSB  = 3;
    localparam int PADDR_LSB  = 0;
    localparam logic [7:0] NODE_ADDR_MASK = 8'h1f;
    localparam logic [7:0] RESET_DATA     = 8'h00;
    localparam logic [3:0] WDT_OFF        = 4'h0;
    localparam logic [3:0] WDT_LAST       = 4'hb;

    // ***************************************************
    // Timing
    // ***************************************************
    localparam int CLK_MHZ = 125;
    localparam int CNT_W   = 27;
    // Timeouts in microseconds, index = code - 1
    localparam int WDT_US [11] = '{200, 500, 1000, 2000, 5000, 10000,
                                   20000, 50000, 100000, 200000, 500000};
    // Break wait in tenths of a microsecond, index = code
    localparam int BWT_TENTH_US [8] = '{10000, 1250, 2500, 5000,
                                        12500, 25000, 50000, 50000};

    typedef enum logic [1:0] {NVM_IDLE, NVM_LOAD, NVM_DONE} load_state_t;
endpackage

/* cfg_load_if.sv */
// Interface: watchdog select, frame, enable and timeout between modules
interface cfg_load_if;
    logic [3:0] wdt_sel;
    logic       frame_ok;
    logic       enable;
    logic       timeout;
    modport ctrl (output wdt_sel, output frame_ok, output enable,
                  input timeout);
    modport wdog (input wdt_sel, input frame_ok, input enable,
                  output timeout);
endinterface

/* comm_watchdog.sv */
// Communication watchdog: counts idle host time against the selected timeout
module comm_watchdog
    import link_cfg_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    cfg_load_if.wdog  bus
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             timeout;
    } wd_state_t;

    wd_state_t        cur;
    wd_state_t        next_st;
    logic [CNT_W-1:0] limit;

    always_comb begin
        limit = '0;
        for (int i = 0; i < 11; i++) begin
            if (bus.wdt_sel == 4'(i + 1)) begin
                limit = CNT_W'(WDT_US[i] * CLK_MHZ); // RQ2
            end
        end
    end

    always_comb begin
        next_st = cur;
        if (bus.wdt_sel == WDT_OFF) begin
            next_st.cnt     = '0; // RQ1
            next_st.timeout = 1'b0;
        end else if (bus.wdt_sel > WDT_LAST) begin
            next_st.timeout = 1'b1; // RQ3
        end else if (bus.frame_ok) begin
            next_st.cnt = '0; // RQ9
        end else if (!cur.timeout) begin
            if (cur.cnt >= limit - CNT_W'(1)) begin
                next_st.timeout = 1'b1; // RQ9
            end else begin
                next_st.cnt = cur.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cur <= '0;
        end else if (bus.enable) begin
            cur <= next_st;
        end
    end

    assign bus.timeout = cur.timeout;
endmodule

/* strap_sync.sv */
// Two-flop synchroniser for the address strap pins
module strap_sync #(
    parameter int W = 3
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_st;

    always_comb begin
        next_st    = cur;
        next_st.s1 = d_i;
        next_st.s2 = cur.s1;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cur <= '0;
        end else if (ce_i) begin
            cur <= next_st;
        end
    end

    assign q_o = cur.s2;
endmodule

/* serial_link_config_regs.sv */
// Link configuration registers with NVM load, address select and watchdog
// How it works
// RQ1 - Bits 7:4 of link timing pick the watchdog; zero disables it.
// RQ2 - Codes 1h..Bh select 200 us up to 500 ms timeouts in order.
// RQ3 - Codes Ch..Fh force fail-safe entry at once.
// RQ4 - Bits 3:1 pick break wait; 6h and 7h both give 5 ms.
// RQ5 - Bit 0 of link timing enables acknowledgement replies.
// RQ6 - Node address bit 4 picks strap pins (0) or programmed field (1).
// RQ7 - Programmed bits 3:0 form the binary node address directly.
// RQ8 - After reset every writable field loads from nonvolatile memory.
// RQ9 - Each valid host frame restarts the watchdog; expiry enters fail-safe.
//
// The address-and-strobe port is this design's own decision.
module serial_link_config_regs
    import link_cfg_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [7:0]  nvm_timing_i,
    input  wire logic [7:0]  nvm_node_i,
    input  wire logic [7:0]  nvm_init_i,
    input  wire logic        nvm_valid_i,
    output logic             nvm_req_o,
    input  wire logic        address_strap_bit2_i,
    input  wire logic        address_strap_bit1_i,
    input  wire logic        address_strap_bit0_i,
    input  wire logic        frame_ok_i,
    output logic      [3:0]  node_address_o,
    output logic             ack_reply_enable_o,
    output logic      [2:0]  break_wait_time_sel_o,
    output logic [CNT_W-1:0] break_wait_cycles_o,
    output logic             fail_safe_o,
    output logic             cfg_loaded_o
);

    // ***************************************************
    // State
    // ***************************************************
    typedef struct packed {
        load_state_t      ld;
        logic [7:0]       link_timing_config;
        logic [7:0]       node_address_config;
        logic [7:0]       link_init_config;
        logic [7:0]       rdata;
        logic             nvm_req;
        logic [3:0]       node_addr;
        logic             ack_en;
        logic [2:0]       bwt_sel;
        logic [CNT_W-1:0] bwt_cycles;
        logic             fail_safe;
        logic             loaded;
        logic [CNT_W-1:0] quiet;
    } regs_state_t;

    regs_state_t cur;
    regs_state_t next_st;

    cfg_load_if  wd_bus ();
    logic [2:0]  strap;
    logic [3:0]  sel_addr;
    logic [CNT_W-1:0] bwt_calc;

    // ***************************************************
    // Submodules
    // ***************************************************
    // Straps come from pins, so they are synchronised before use
    strap_sync #(.W(3)) u_strap (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .d_i       ({address_strap_bit2_i, address_strap_bit1_i,
                     address_strap_bit0_i}),
        .q_o       (strap)
    );

    comm_watchdog u_wdog (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .bus       (wd_bus.wdog)
    );

    // Watchdog is held off until the NVM image is in, so stale zeros
    // from reset never count as a configuration
    assign wd_bus.wdt_sel  = (cur.ld == NVM_DONE)
                           ? cur.link_timing_config[WDT_MSB:WDT_LSB]
                           : WDT_OFF;
    assign wd_bus.frame_ok = frame_ok_i;
    assign wd_bus.enable   = ce_i;

    // ***************************************************
    // Decode
    // ***************************************************
    always_comb begin
        sel_addr = cur.node_address_config[INTSEL_BIT]
                 ? cur.node_address_config[PADDR_MSB:PADDR_LSB] // RQ7
                 : {1'b0, strap}; // RQ6
        bwt_calc = CNT_W'((BWT_TENTH_US[cur.link_timing_config
                           [BWT_MSB:BWT_LSB]] * CLK_MHZ) / 10); // RQ4
    end

    always_comb begin
        next_st = cur;
        next_st.nvm_req = 1'b0;
        case (cur.ld)
            NVM_IDLE: begin
                next_st.nvm_req = 1'b1;
                next_st.ld      = NVM_LOAD;
            end
            NVM_LOAD: begin
                next_st.nvm_req = !nvm_valid_i;
                if (nvm_valid_i) begin
                    next_st.link_timing_config  = nvm_timing_i; // RQ8
                    next_st.node_address_config =
                        nvm_node_i & NODE_ADDR_MASK; // RQ8
                    next_st.link_init_config    = nvm_init_i; // RQ8
                    next_st.ld                  = NVM_DONE;
                end
            end
            NVM_DONE: begin
                if (wr_i) begin
                    case (addr_i)
                        LINK_TIMING_OFS: next_st.link_timing_config = wdata_i;
                        NODE_ADDR_OFS:   next_st.node_address_config =
                                             wdata_i & NODE_ADDR_MASK;
                        LINK_INIT_OFS:   next_st.link_init_config = wdata_i;
                        default: ;
                    endcase
                end
            end
            default: next_st.ld = NVM_IDLE;
        endcase
        // Reads answer in the next cycle; unmapped addresses read zero
        next_st.rdata = RESET_DATA;
        if (rd_i) begin
            case (addr_i)
                LINK_TIMING_OFS: next_st.rdata = cur.link_timing_config;
                NODE_ADDR_OFS:   next_st.rdata = cur.node_address_config;
                LINK_INIT_OFS:   next_st.rdata = cur.link_init_config;
                default:         next_st.rdata = RESET_DATA;
            endcase
        end
        next_st.node_addr  = sel_addr;
        next_st.ack_en     = cur.link_timing_config[ACK_BIT]; // RQ5
        next_st.bwt_sel    = cur.link_timing_config[BWT_MSB:BWT_LSB];
        next_st.bwt_cycles = bwt_calc;
        next_st.fail_safe  = wd_bus.timeout; // RQ9
        next_st.loaded     = (next_st.ld == NVM_DONE);
        // Run of quiet cycles under the shortest timeout; only the checks
        // read it, so a write or a frame simply starts it over
        next_st.quiet      = '0;
        if (cur.ld == NVM_DONE && !frame_ok_i && !wr_i
            && cur.link_timing_config[WDT_MSB:WDT_LSB] == 4'h1) begin
            next_st.quiet = (cur.quiet == '1) ? cur.quiet
                                              : cur.quiet + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cur <= '0;
        end else if (ce_i) begin
            cur <= next_st;
        end
    end

    assign rdata_o               = cur.rdata;
    assign nvm_req_o             = cur.nvm_req;
    assign node_address_o        = cur.node_addr;
    assign ack_reply_enable_o    = cur.ack_en;
    assign break_wait_time_sel_o = cur.bwt_sel;
    assign break_wait_cycles_o   = cur.bwt_cycles;
    assign fail_safe_o           = cur.fail_safe;
    assign cfg_loaded_o          = cur.loaded;

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // The watchdog sees a code one edge later and the output register
    // one edge after that, so a code change shows two edges on
    wdt_off_safe_a: assert property ( // RQ1
        ce_i && cur.link_timing_config[WDT_MSB:WDT_LSB] == WDT_OFF
        ##1 ce_i ##1 ce_i |-> !fail_safe_o)
        else $error("Watchdog off but fail-safe raised");
    wdt_force_fs_a: assert property ( // RQ3
        cur.ld == NVM_DONE && ce_i
        && cur.link_timing_config[WDT_MSB:WDT_LSB] > WDT_LAST
        ##1 ce_i |=> fail_safe_o)
        else $error("Codes Ch..Fh did not force fail-safe");
    // The long wait is counted in the quiet field, too long for a range
    wdt_short_a: assert property ( // RQ2
        cur.quiet >= CNT_W'(WDT_US[0] * CLK_MHZ + 1) |-> fail_safe_o)
        else $error("200 us watchdog did not expire");
    bwt_decode_a: assert property ( // RQ4
        ce_i && cur.link_timing_config[BWT_MSB:BWT_LSB] == 3'h1
        |=> break_wait_cycles_o == CNT_W'(15625))
        else $error("Break wait decode wrong");
    ack_follow_a: assert property ( // RQ5
        ce_i |=> ack_reply_enable_o == $past(cur.link_timing_config[ACK_BIT]))
        else $error("Ack enable does not follow register");
    addr_prog_a: assert property ( // RQ7
        ce_i && cur.node_address_config[INTSEL_BIT]
        |=> node_address_o == $past(cur.node_address_config[3:0]))
        else $error("Programmed address not used");
    addr_strap_a: assert property ( // RQ6
        ce_i && !cur.node_address_config[INTSEL_BIT]
        |=> node_address_o == {1'b0, $past(strap)})
        else $error("Strap address not used");
    nvm_load_a: assert property ( // RQ8
        cur.ld == NVM_LOAD && nvm_valid_i && ce_i
        |=> cur.link_timing_config == $past(nvm_timing_i) && cfg_loaded_o)
        else $error("NVM image not loaded");
    frame_restart_a: assert property ( // RQ9
        ce_i && frame_ok_i && cur.ld == NVM_DONE
        && cur.link_timing_config[WDT_MSB:WDT_LSB] inside {[4'h1:4'hb]}
        |=> u_wdog.cur.cnt == '0)
        else $error("Frame did not restart watchdog");

    wdt_off_count_a: assert property ( // RQ1
        ce_i && wd_bus.wdt_sel == WDT_OFF |=> u_wdog.cur.cnt == '0)
        else $error("Disabled watchdog kept counting");
    bwt_sel_a: assert property ( // RQ4
        ce_i |=> break_wait_time_sel_o
                 == $past(cur.link_timing_config[BWT_MSB:BWT_LSB]))
        else $error("Break wait select does not follow register");
    nvm_req_a: assert property ( // RQ8
        ce_i && cur.ld == NVM_LOAD && !nvm_valid_i |=> nvm_req_o)
        else $error("Image request dropped while loading");
    early_wr_a: assert property ( // RQ8
        ce_i && cur.ld != NVM_DONE && !nvm_valid_i
        |=> $stable(cur.link_timing_config))
        else $error("Config changed before the load");

    // ***************************************************
    // Checks: register bus and clock enable
    // ***************************************************
    rd_timing_a: assert property (
        ce_i && rd_i && addr_i == LINK_TIMING_OFS
        |=> rdata_o == $past(cur.link_timing_config))
        else $error("Read data of link timing wrong");
    rd_idle_a: assert property (
        ce_i && !rd_i |=> rdata_o == RESET_DATA)
        else $error("Read data did not return to zero");
    node_mask_a: assert property (
        cur.node_address_config[7:5] == 3'h0)
        else $error("Reserved node address bits set");
    // A stalled edge must leave every register of every submodule alone
    ce_freeze_a: assert property (
        !ce_i |=> $stable(cur) && $stable(u_wdog.cur)
                  && $stable(u_strap.cur))
        else $error("State moved while clock enable low");

    // ***************************************************
    // Coverage
    // ***************************************************
    load_done_c: cover property (cur.ld == NVM_LOAD ##1 cur.ld == NVM_DONE);
    fs_entry_c: cover property (!fail_safe_o ##1 fail_safe_o);
    prog_addr_c: cover property (wr_i && addr_i == NODE_ADDR_OFS);
    ce_stall_c: cover property (!ce_i ##1 ce_i);
    wdt_expire_c: cover property (
        fail_safe_o && cur.quiet != '0);
endmodule

/* host_model.sv */
// Far-side model: nonvolatile image source and host frame traffic
module host_model #(
    parameter int FRAME_GAP = 10000
) (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       nvm_req_i,
    input  wire logic       frames_on_i,
    input  wire logic [7:0] img_timing_i,
    input  wire logic [7:0] img_node_i,
    input  wire logic [7:0] img_init_i,
    output logic            nvm_valid_o,
    output logic      [7:0] nvm_timing_o,
    output logic      [7:0] nvm_node_o,
    output logic      [7:0] nvm_init_o,
    output logic            frame_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  dly;
    logic [15:0] fcnt;
    // ***************************************************
    // Image load, held until the device stops asking
    // ***************************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            dly         <= 4'h0;
            nvm_valid_o <= 1'b0;
            fcnt        <= 16'h0;
            frame_ok_o  <= 1'b0;
        end else begin
            dly         <= !nvm_req_i ? 4'h0 :
                           (dly == 4'h4 ? dly : dly + 4'h1);
            nvm_valid_o <= nvm_req_i && dly == 4'h4;
            // Periodic valid frames keep the device watchdog quiet
            frame_ok_o  <= frames_on_i && fcnt == 16'(FRAME_GAP - 1);
            fcnt        <= (!frames_on_i || fcnt == 16'(FRAME_GAP - 1)) ?
                           16'h0 : fcnt + 16'h1;
        end
    end
    // Image is not trustworthy outside valid, so show its inverse there
    assign nvm_timing_o = nvm_valid_o ? img_timing_i : ~img_timing_i;
    assign nvm_node_o   = nvm_valid_o ? img_node_i : ~img_node_i;
    assign nvm_init_o   = nvm_valid_o ? img_init_i : ~img_init_i;
endmodule

/* tb.sv */
// Testbench: register access, decode outputs and watchdog of the link config
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import link_cfg_pkg::*;
    logic             mclk_i, sys_rst_i, wr_i, rd_i, rd_q, frames_on, ce;
    logic [7:0]       addr_i, wdata_i, rdata_o, nvm_timing_i, nvm_node_i;
    logic [7:0]       nvm_init_i, img_init;
    logic             nvm_valid_i, nvm_req_o, frame_ok_i, ack_reply_enable_o;
    logic [2:0]       straps;
    logic [3:0]       node_address_o;
    logic [2:0]       break_wait_time_sel_o;
    logic [CNT_W-1:0] break_wait_cycles_o;
    logic             fail_safe_o, cfg_loaded_o;
    logic [7:0]       rexp [$];
    int               fail_count, n_tests, since;
    serial_link_config_regs serial_link_config_regs_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .nvm_timing_i(nvm_timing_i),
        .nvm_node_i(nvm_node_i), .nvm_init_i(nvm_init_i),
        .nvm_valid_i(nvm_valid_i), .nvm_req_o(nvm_req_o),
        .address_strap_bit2_i(straps[2]), .address_strap_bit1_i(straps[1]),
        .address_strap_bit0_i(straps[0]), .frame_ok_i(frame_ok_i),
        .node_address_o(node_address_o),
        .ack_reply_enable_o(ack_reply_enable_o),
        .break_wait_time_sel_o(break_wait_time_sel_o),
        .break_wait_cycles_o(break_wait_cycles_o),
        .fail_safe_o(fail_safe_o), .cfg_loaded_o(cfg_loaded_o));
    host_model host_model_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .nvm_req_i(nvm_req_o),
        .frames_on_i(frames_on), .img_timing_i(8'h0b), .img_node_i(8'h1a),
        .img_init_i(img_init), .nvm_valid_o(nvm_valid_i),
        .nvm_timing_o(nvm_timing_i), .nvm_node_o(nvm_node_i),
        .nvm_init_o(nvm_init_i), .frame_ok_o(frame_ok_i));
    // ***************************************************
    // Clock, checks and bus tasks
    // ***************************************************
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        rexp.push_back(e);
        @(posedge mclk_i);
        rd_i   <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_q) check(rdata_o, rexp.pop_front());
        rd_q  <= rd_i;
        since <= frame_ok_i ? 0 : since + 1;
    end
    // ***************************************************
    // Scenarios
    // ***************************************************
    initial begin
        {wr_i, rd_i, frames_on, addr_i, wdata_i} = '0;
        ce = 1'b1;
        void'($urandom(32'hc8bbf03f));
        img_init  = 8'($urandom());
        straps    = 3'($urandom());
        sys_rst_i = 1'b1;
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (40) @(posedge mclk_i);
        check(cfg_loaded_o, 1'b1);
        bus_rd(LINK_TIMING_OFS, 8'h0b);
        bus_rd(NODE_ADDR_OFS, 8'h1a);
        bus_rd(LINK_INIT_OFS, img_init);
        check(ack_reply_enable_o, 1'b1);
        check(node_address_o, 4'ha);
        check(break_wait_time_sel_o, 3'h5);
        check(fail_safe_o, 1'b0);
        // Strap select, upper bits of the byte never stick
        bus_wr(NODE_ADDR_OFS, 8'he3);
        bus_rd(NODE_ADDR_OFS, 8'h03);
        repeat (4) @(posedge mclk_i);
        check(node_address_o, {1'b0, straps});
        bus_wr(NODE_ADDR_OFS, 8'h1c);
        repeat (2) @(posedge mclk_i);
        check(node_address_o, 4'hc);
        for (int c = 0; c < 8; c++) begin
            bus_wr(LINK_TIMING_OFS, 8'(c << 1));
            // Field lands on the write edge, decoded outputs one edge later
            repeat (2) @(posedge mclk_i);
            check(break_wait_cycles_o,
                  32'(BWT_TENTH_US[c] * CLK_MHZ / 10));
            check(ack_reply_enable_o, 1'b0);
        end
        // Unmapped write leaves the mapped bytes alone
        bus_wr(8'h87, 8'hff);
        // A write while the clock enable is low must not land
        ce <= 1'b0;
        bus_wr(LINK_TIMING_OFS, 8'h01);
        ce <= 1'b1;
        bus_rd(LINK_TIMING_OFS, 8'h0e);
        for (int c = 12; c < 16; c++) begin
            bus_wr(LINK_TIMING_OFS, 8'(c << 4));
            repeat (3) @(posedge mclk_i);
            check(fail_safe_o, 1'b1);
            bus_wr(LINK_TIMING_OFS, 8'h00);
            repeat (3) @(posedge mclk_i);
            check(fail_safe_o, 1'b0);
        end
        // Frames every 10000 cycles stay well inside the 200 us limit
        frames_on <= 1'b1;
        bus_wr(LINK_TIMING_OFS, 8'h10);
        repeat (32000) @(posedge mclk_i);
        check(fail_safe_o, 1'b0);
        frames_on <= 1'b0;
        for (int i = 0; i < 40000 && fail_safe_o !== 1'b1; i++)
            @(posedge mclk_i);
        @(posedge mclk_i);
        check(since >= WDT_US[0] * CLK_MHZ && since <= WDT_US[0] * CLK_MHZ + 6,
              1'b1);
        results();
    end
    initial begin
        #720000;
        fail_count++;
        results();
    end
endmodule
